// file: design/scpt_top.sv
// synthesizer calibration, core power sequencing and output power table
// Functional notes
// [RULE_01] host calibrates after power-up and channel change
// [RULE_02] autocal on synth turn-on or turn-off
// [RULE_03] calibrate strobe in idle starts calibration
// [RULE_04] calibration result kept through sleep
// [RULE_05] select 0x0a puts lock on output
// [RULE_06] result reads 0x3f when unlocked
// [RULE_07] host repeats calibration until locked
// [RULE_08] host checks lock, recalibrates if lost
// [RULE_09] chip select low powers core, oscillator
// [RULE_10] data out low when ready, host waits
// [RULE_11] power-down strobe: off at chip select high
// [RULE_12] eight-entry table chosen by 3-bit index
// [RULE_13] ramp entries zero up to index
// [RULE_14] index zero: no ramp, entry zero
// [RULE_15] host loads ook levels in entries 0,1
// [RULE_16] host avoids entries 0x61 to 0x6f
// [RULE_17] only burst writes reach entries above zero
// [RULE_18] sleep loses all entries but zero
// [RULE_19] default table setting is 0xc6
// [RULE_20] ask counter at 8x symbol rate, saturating
`timescale 1ns/1ps
`default_nettype none
module scpt_top #(
   parameter int CAL_CYCLES  = scpt_pkg::CAL_CYCLES,  // calibration length
   parameter int WAKE_CYCLES = scpt_pkg::WAKE_CYCLES  // core wake delay
) (
   input  wire logic                 clock_in,              // 50 MHz core clock
   input  wire logic                 resetn_in,             // async reset
   input  wire logic                 enable_in,             // clock enable
   input  wire logic                 chip_select_n_in,      // serial select pin
   input  wire logic                 calibrate_strobe_in,   // manual cal pulse
   input  wire logic                 power_down_strobe_in,  // power-down pulse
   input  wire logic                 idle_in,               // radio in idle
   input  wire logic                 synth_on_in,           // synth running
   input  wire logic                 synth_auto_off_in,     // synth turning off auto
   input  wire logic                 pll_lock_in,           // analogue lock level
   input  wire logic [1:0]           synth_autocal_select_in,
   input  wire logic [5:0]           gp_output_select_in,   // pin function select
   input  wire logic [2:0]           power_table_index_in,  // selected top entry
   input  wire scpt_pkg::scpt_tbl_wr_t tbl_wr_in,           // table write
   input  wire scpt_pkg::scpt_tx_ctl_t tx_ctl_in,           // tx shaping control
   output logic                      core_power_out,        // core regulator on
   output logic                      xosc_enable_out,       // oscillator on
   output logic                      so_out,                // serial data out level
   output logic                      so_oe_out,             // serial data out enable
   output logic                      gp_output_out,         // general output pin
   output logic                      cal_busy_out,          // calibration running
   output logic                      cal_start_out,         // pulse: cal started
   output logic [5:0]                synth_cal_result_out,  // result register
   output logic [7:0]                pa_setting_out,        // applied power setting
   output logic [2:0]                pa_index_out           // applied table index
);
   localparam int TD = scpt_pkg::TABLE_DEPTH;

   scpt_pkg::scpt_cal_state_t cal_q;   // calibration state
   scpt_pkg::scpt_pwr_state_t pwr_q;   // power state
   logic [19:0]  cal_cnt_q;            // calibration timer
   logic [15:0]  wake_cnt_q;           // wake timer
   logic [5:0]   cal_val_q;            // calibration code held
   logic         synth_on_prev_q;      // edge detect of synth on
   logic         auto_off_prev_q;      // edge detect of auto off
   logic [7:0]   table_q [TD];         // output power table
   logic [2:0]   ramp_q;               // ramp / ask counter
   logic         cs_level, cs_fall;    // synchronised chip select
   logic         lock_level;           // synchronised lock
   logic         cal_req;              // any calibration trigger
   logic         core_up;              // core ready (on or armed)

   // chip select pin crosses into the core clock
   scpt_sync3 u_cs_sync (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .enable_in (enable_in),
      .async_in  (chip_select_n_in),
      .level_out (cs_level),
      .rise_out  (),
      .fall_out  (cs_fall)
   );

   // lock detector is analogue, so it crosses too; rests unlocked so
   // reset never shows a false lock edge on the pin
   scpt_sync3 #(.IDLE(1'b0)) u_lock_sync (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .enable_in (enable_in),
      .async_in  (pll_lock_in),
      .level_out (lock_level),
      .rise_out  (),
      .fall_out  ()
   );

   assign core_up = (pwr_q == scpt_pkg::SCPT_PWR_ON) ||
                    (pwr_q == scpt_pkg::SCPT_PWR_ARMED);

   // power sequencing on chip select and power-down strobe
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pwr_q      <= scpt_pkg::SCPT_PWR_WAKE;
         wake_cnt_q <= '0;
      end else if (enable_in) begin
         unique case (pwr_q)
            scpt_pkg::SCPT_PWR_OFF: begin
               if (cs_fall || !cs_level) begin // [RULE_09] [RULE_11]
                  pwr_q      <= scpt_pkg::SCPT_PWR_WAKE;
                  wake_cnt_q <= '0;
               end
            end
            scpt_pkg::SCPT_PWR_WAKE: begin
               // oscillator settling before ready
               if (wake_cnt_q >= 16'(WAKE_CYCLES - 1)) begin
                  pwr_q <= scpt_pkg::SCPT_PWR_ON;
               end else begin
                  wake_cnt_q <= wake_cnt_q + 16'h0001;
               end
            end
            scpt_pkg::SCPT_PWR_ON: begin
               if (power_down_strobe_in) begin
                  pwr_q <= scpt_pkg::SCPT_PWR_ARMED;
               end
            end
            scpt_pkg::SCPT_PWR_ARMED: begin
               if (cs_level) begin // [RULE_11]
                  pwr_q <= scpt_pkg::SCPT_PWR_OFF;
               end
            end
         endcase
      end
   end

   // regulator, oscillator and ready indication on serial out
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         core_power_out  <= 1'b1;
         xosc_enable_out <= 1'b1;
         so_out          <= 1'b1;
         so_oe_out       <= 1'b0;
      end else if (enable_in) begin
         core_power_out  <= pwr_q != scpt_pkg::SCPT_PWR_OFF; // [RULE_09]
         xosc_enable_out <= pwr_q != scpt_pkg::SCPT_PWR_OFF; // [RULE_09]
         so_out          <= !core_up;            // [RULE_10] low once ready
         so_oe_out       <= !cs_level;           // driven while selected
      end
   end

   // calibration triggers: auto on synth edges, manual in idle
   always_comb begin
      cal_req = 1'b0;
      if (synth_autocal_select_in == scpt_pkg::AUTOCAL_ON &&
          synth_on_in && !synth_on_prev_q) begin
         cal_req = 1'b1; // [RULE_02]
      end
      if (synth_autocal_select_in == scpt_pkg::AUTOCAL_OFF &&
          synth_auto_off_in && !auto_off_prev_q) begin
         cal_req = 1'b1; // [RULE_02]
      end
      if (calibrate_strobe_in && idle_in) begin
         cal_req = 1'b1; // [RULE_03]
      end
   end

   // edge memories for the synthesizer status
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         synth_on_prev_q <= 1'b0;
         auto_off_prev_q <= 1'b0;
      end else if (enable_in) begin
         synth_on_prev_q <= synth_on_in;
         auto_off_prev_q <= synth_auto_off_in;
      end
   end

   // calibration sequencer
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cal_q         <= scpt_pkg::SCPT_CAL_IDLE;
         cal_cnt_q     <= '0;
         cal_start_out <= 1'b0;
         cal_busy_out  <= 1'b0;
      end else if (enable_in) begin
         cal_start_out <= 1'b0;
         unique case (cal_q)
            scpt_pkg::SCPT_CAL_IDLE, scpt_pkg::SCPT_CAL_DONE: begin
               if (cal_req && core_up) begin
                  cal_q         <= scpt_pkg::SCPT_CAL_RUN;
                  cal_cnt_q     <= '0;
                  cal_start_out <= 1'b1;
                  cal_busy_out  <= 1'b1;
               end
            end
            scpt_pkg::SCPT_CAL_RUN: begin
               if (cal_cnt_q >= 20'(CAL_CYCLES - 1)) begin
                  cal_q        <= scpt_pkg::SCPT_CAL_DONE;
                  cal_busy_out <= 1'b0;
               end else begin
                  cal_cnt_q <= cal_cnt_q + 20'h00001;
               end
            end
         endcase
      end
   end

   // calibration code: captured at end of calibration, never cleared by sleep
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cal_val_q <= scpt_pkg::CAL_RESET_VAL;
      end else if (enable_in && cal_q == scpt_pkg::SCPT_CAL_RUN &&
                   cal_cnt_q >= 20'(CAL_CYCLES - 1)) begin
         // code from cycle count, kept distinct from the unlock value
         cal_val_q <= lock_level ? {1'b0, cal_cnt_q[4:0]} : // [RULE_04]
                      scpt_pkg::CAL_UNLOCKED;
      end
   end

   // result register and lock pin
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         synth_cal_result_out <= scpt_pkg::CAL_RESET_VAL;
         gp_output_out        <= 1'b0;
      end else if (enable_in) begin
         synth_cal_result_out <= lock_level ? cal_val_q :
                                 scpt_pkg::CAL_UNLOCKED; // [RULE_06]
         gp_output_out <= (gp_output_select_in == scpt_pkg::GPO_LOCK_SEL)
                          && lock_level; // [RULE_05] rises on lock
      end
   end

   // power table; sleep clears all but entry zero
   for (genvar i = 0; i < TD; i++) begin : g_table
      always_ff @(posedge clock_in or negedge resetn_in) begin
         if (!resetn_in) begin
            table_q[i] <= scpt_pkg::PWR_DEFAULT; // [RULE_19]
         end else if (enable_in) begin
            if (i != 0 && pwr_q == scpt_pkg::SCPT_PWR_OFF) begin
               table_q[i] <= 8'h00; // [RULE_18]
            end else if (tbl_wr_in.wr && tbl_wr_in.idx == 3'(i) &&
                         (tbl_wr_in.burst || i == 0)) begin
               table_q[i] <= tbl_wr_in.data; // [RULE_12] [RULE_17]
            end
         end
      end
   end

   // ramp index: up to selected index while on, down when off;
   // index zero drops to entry zero at once, without waiting for a tick
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ramp_q <= '0;
      end else if (enable_in && (tx_ctl_in.sym_tick ||
                                 power_table_index_in == 3'h0)) begin
         if (power_table_index_in == 3'h0) begin
            ramp_q <= 3'h0; // [RULE_14]
         end else if (tx_ctl_in.ook) begin
            ramp_q <= {2'b00, tx_ctl_in.data_bit}; // entries 0 and 1
         end else if (tx_ctl_in.ask) begin
            // count up on ones, down on zeros, saturating [RULE_20]
            if (tx_ctl_in.data_bit && ramp_q < power_table_index_in) begin
               ramp_q <= ramp_q + 3'h1;
            end else if (!tx_ctl_in.data_bit && ramp_q != 3'h0) begin
               ramp_q <= ramp_q - 3'h1;
            end
         end else if (tx_ctl_in.tx_on && ramp_q < power_table_index_in) begin
            ramp_q <= ramp_q + 3'h1; // [RULE_13] ramp up
         end else if (!tx_ctl_in.tx_on && ramp_q != 3'h0) begin
            ramp_q <= ramp_q - 3'h1; // [RULE_13] ramp down
         end else if (ramp_q > power_table_index_in) begin
            ramp_q <= power_table_index_in;
         end
      end
   end

   // applied setting
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pa_index_out   <= '0;
         pa_setting_out <= scpt_pkg::PWR_DEFAULT;
      end else if (enable_in) begin
         pa_index_out   <= ramp_q;
         pa_setting_out <= table_q[ramp_q]; // [RULE_12]
      end
   end
endmodule : scpt_top
`default_nettype wire

// file: shared/scpt_pkg.sv
// package: constants, states and carriers for the synth cal / power table block
package scpt_pkg;
   localparam int          CLK_HZ          = 50_000_000;      // core clock rate
   localparam int          CAL_TIME_NS     = 724_000;         // calibration length
   localparam int          CAL_CYCLES      = (CAL_TIME_NS / 1000) * (CLK_HZ / 1_000_000); // rounds down
   localparam int          WAKE_TIME_NS    = 2_000;           // regulator/osc start
   localparam int          WAKE_CYCLES     = (WAKE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [5:0]  GPO_LOCK_SEL    = 6'h0a;           // lock detector select
   localparam logic [5:0]  CAL_UNLOCKED    = 6'h3f;           // result when unlocked
   localparam logic [5:0]  CAL_RESET_VAL   = 6'h3f;           // result after reset
   localparam logic [7:0]  PWR_DEFAULT     = 8'hc6;           // default table entry
   localparam int          TABLE_DEPTH     = 8;               // entries in table
   localparam int          ASK_OVERSAMPLE  = 8;               // counter rate / symbol
   localparam logic [1:0]  AUTOCAL_NEVER   = 2'h0;            // manual only
   localparam logic [1:0]  AUTOCAL_ON      = 2'h1;            // cal when synth on
   localparam logic [1:0]  AUTOCAL_OFF     = 2'h2;            // cal when synth off

   // calibration machine, one-hot
   typedef enum logic [2:0] {
      SCPT_CAL_IDLE = 3'b001,
      SCPT_CAL_RUN  = 3'b010,
      SCPT_CAL_DONE = 3'b100
   } scpt_cal_state_t;

   // power sequencing machine, one-hot
   typedef enum logic [3:0] {
      SCPT_PWR_OFF   = 4'b0001,
      SCPT_PWR_WAKE  = 4'b0010,
      SCPT_PWR_ON    = 4'b0100,
      SCPT_PWR_ARMED = 4'b1000
   } scpt_pwr_state_t;

   // table write request
   typedef struct packed {
      logic       wr;    // write strobe
      logic       burst; // burst access may address any entry
      logic [2:0] idx;   // entry addressed
      logic [7:0] data;  // power setting
   } scpt_tbl_wr_t;

   // transmit shaping controls
   typedef struct packed {
      logic       tx_on;     // transmitter active
      logic       ask;       // ask shaping mode
      logic       ook;       // ook mode
      logic       data_bit;  // current symbol value
      logic       sym_tick;  // one pulse per symbol/8
   } scpt_tx_ctl_t;
endpackage : scpt_pkg

// file: design/scpt_sync3.sv
// three-stage input synchroniser with agreement-based edge detection
`timescale 1ns/1ps
`default_nettype none
module scpt_sync3 #(
   parameter logic IDLE = 1'b1   // pin level at rest, held through reset
) (
   input  wire logic clock_in,   // core clock
   input  wire logic resetn_in,  // async reset, active low
   input  wire logic enable_in,  // clock enable
   input  wire logic async_in,   // raw pin level
   output logic      level_out,  // settled level
   output logic      rise_out,   // one-cycle pulse on settled rise
   output logic      fall_out    // one-cycle pulse on settled fall
);
   logic s1_q, s2_q, s3_q; // shift stages
   logic lvl_q;            // accepted level

   // shift chain; first stage feeds only the second
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_q <= IDLE;
         s2_q <= IDLE;
         s3_q <= IDLE;
      end else if (enable_in) begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lvl_q <= IDLE;
      end else if (enable_in && (s2_q == s3_q)) begin
         lvl_q <= s3_q;
      end
   end

   assign level_out = lvl_q;
   assign rise_out  = enable_in && (s2_q == s3_q) && s3_q && !lvl_q;
   assign fall_out  = enable_in && (s2_q == s3_q) && !s3_q && lvl_q;
endmodule : scpt_sync3
`default_nettype wire

// file: testbench/scpt_checker.sv
// concurrent checks on the synth cal / power table block ports
`timescale 1ns/1ps
`default_nettype none
module scpt_checker #(
   parameter int CAL_CYCLES = 20                      // calibration length
) (
   input wire logic                   clock_in,             // core clock
   input wire logic                   resetn_in,            // async reset
   input wire logic                   enable_in,            // clock enable
   input wire logic                   chip_select_n_in,     // select pin
   input wire logic                   pll_lock_in,          // lock level
   input wire logic [5:0]             gp_output_select_in,  // pin function
   input wire logic [2:0]             power_table_index_in, // top entry
   input wire scpt_pkg::scpt_tx_ctl_t tx_ctl_in,            // shaping ctl
   input wire logic                   core_power_out,       // core on
   input wire logic                   xosc_enable_out,      // osc on
   input wire logic                   so_out,               // data out
   input wire logic                   gp_output_out,        // gp pin
   input wire logic                   cal_busy_out,         // cal running
   input wire logic                   cal_start_out,        // cal pulse
   input wire logic [5:0]             synth_cal_result_out, // result
   input wire logic [2:0]             pa_index_out          // applied index
);
   int busy_cnt_q;                                    // busy cycles so far
   // count busy cycles, cleared while calibration is idle
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) busy_cnt_q <= 0;
      else busy_cnt_q <= cal_busy_out ? busy_cnt_q + 1 : 0;
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   chk_start_pulse: assert property (
      cal_start_out |-> cal_busy_out ##1 !cal_start_out)
      else $error("calibration start is not a one-cycle pulse");
   chk_busy_length: assert property (
      $fell(cal_busy_out) |-> busy_cnt_q == CAL_CYCLES)
      else $error("calibration busy length is wrong");
   chk_lock_high: assert property (
      (enable_in && gp_output_select_in == scpt_pkg::GPO_LOCK_SEL
       && pll_lock_in)[*6] |-> gp_output_out)
      else $error("lock not shown on the gp pin");
   chk_lock_low: assert property (
      (enable_in && gp_output_select_in == scpt_pkg::GPO_LOCK_SEL
       && !pll_lock_in)[*6] |-> !gp_output_out)
      else $error("gp pin shows lock while unlocked");
   chk_result_unlocked: assert property (
      (enable_in && !pll_lock_in)[*6] |->
      synth_cal_result_out == scpt_pkg::CAL_UNLOCKED)
      else $error("result not at unlocked value");
   chk_result_locked: assert property (
      pll_lock_in[*6] ##0 $fell(cal_busy_out) |=>
      synth_cal_result_out != scpt_pkg::CAL_UNLOCKED)
      else $error("locked calibration reads as unlocked");
   chk_wake_select: assert property (
      (enable_in && !chip_select_n_in)[*8] |->
      core_power_out && xosc_enable_out)
      else $error("core not powered with select low");
   chk_off_select: assert property (
      $fell(core_power_out) |-> chip_select_n_in)
      else $error("core powered down with select low");
   chk_so_ready: assert property (
      $fell(so_out) |-> core_power_out && !chip_select_n_in)
      else $error("data out went low before the core was up");
   chk_index_zero: assert property (
      (power_table_index_in == 3'h0 && !tx_ctl_in.ook)[*3] |->
      pa_index_out == 3'h0)
      else $error("index moved with table index zero");
   chk_ramp_step: assert property (
      $changed(pa_index_out) |->
      pa_index_out == $past(pa_index_out) + 3'h1 ||
      pa_index_out == $past(pa_index_out) - 3'h1)
      else $error("power index jumped by more than one");
endmodule // scpt_checker
bind scpt_top scpt_checker #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
   .clock_in, .resetn_in, .enable_in, .chip_select_n_in, .pll_lock_in,
   .gp_output_select_in, .power_table_index_in, .tx_ctl_in,
   .core_power_out, .xosc_enable_out, .so_out, .gp_output_out,
   .cal_busy_out, .cal_start_out, .synth_cal_result_out, .pa_index_out);
`default_nettype wire

// file: testbench/scpt_host_model.sv
// host model: drives chip select and watches the serial data-out pin
`timescale 1ns/1ps
`default_nettype none
module scpt_host_model (
   input  wire logic clock_in,          // core clock
   input  wire logic wake_req_in,       // bench wants the core up
   input  wire logic so_in,             // data-out level
   input  wire logic so_oe_in,          // data-out driven
   output var  logic chip_select_n_out, // select pin, active low
   output var  logic ready_out          // core reported ready
);
   initial chip_select_n_out = 1'b0;
   initial ready_out = 1'b0;
   // select follows the request, changed just after the edge
   always @(posedge clock_in) chip_select_n_out <= #2 !wake_req_in;
   // a released pin reads high, so only a driven low means ready
   always @(posedge clock_in)
      ready_out <= #2 !chip_select_n_out && so_oe_in && !so_in;
endmodule // scpt_host_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the synth cal / power table block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin checks++; if ((e) !== (g)) begin \
   fail_count++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
   localparam int CAL_T = 20;                 // shortened calibration
   logic       clock_in = 1'b0;               // core clock
   logic       resetn_in = 1'b0;              // async reset
   logic       cal_stb = 1'b0, pd_stb = 1'b0; // strobes
   logic       idle = 1'b0, lock = 1'b0;      // radio state, lock level
   logic       syn_on = 1'b0, syn_off = 1'b0; // synth events
   logic       wake_req = 1'b1;               // host keeps core up
   logic [1:0] acal = 2'h0;                   // autocal mode
   logic [5:0] gsel = 6'h00;                  // pin function
   logic [2:0] pidx = 3'h0;                   // top entry
   scpt_pkg::scpt_tbl_wr_t wr = '0;           // table write
   scpt_pkg::scpt_tx_ctl_t tx = '0;           // shaping controls
   logic       cs_n, pwr, xosc, so, so_oe, gp, busy, start, ready;
   logic [5:0] res;                           // result seen
   logic [7:0] pa, pa_last, lastv, ev;        // power settings
   logic [2:0] pai;                           // applied index
   logic [7:0] tbl [8];                       // expected table
   logic [7:0] pa_q [$];                      // expected setting changes
   logic       cal_q [$];                     // expected lock per cal
   logic       tx_watch = 1'b0, busy_prev = 1'b0, eb;
   int         fail_count = 0, checks = 0, starts = 0, cal_wait = 0;
   initial forever #10 clock_in = ~clock_in;
   scpt_top #(.CAL_CYCLES(CAL_T), .WAKE_CYCLES(4)) uut (
      .clock_in, .resetn_in, .enable_in(1'b1), .chip_select_n_in(cs_n),
      .calibrate_strobe_in(cal_stb), .power_down_strobe_in(pd_stb),
      .idle_in(idle), .synth_on_in(syn_on), .synth_auto_off_in(syn_off),
      .pll_lock_in(lock), .synth_autocal_select_in(acal),
      .gp_output_select_in(gsel), .power_table_index_in(pidx),
      .tbl_wr_in(wr), .tx_ctl_in(tx), .core_power_out(pwr),
      .xosc_enable_out(xosc), .so_out(so), .so_oe_out(so_oe),
      .gp_output_out(gp), .cal_busy_out(busy), .cal_start_out(start),
      .synth_cal_result_out(res), .pa_setting_out(pa), .pa_index_out(pai));
   scpt_host_model host (.clock_in, .wake_req_in(wake_req), .so_in(so),
      .so_oe_in(so_oe), .chip_select_n_out(cs_n), .ready_out(ready));
   // monitor: compares each output change with the oldest note
   always @(posedge clock_in) begin
      if (tx_watch && pa !== pa_last) begin
         `CHECK("pa_note", 1, pa_q.size() > 0)
         ev = pa_q.pop_front();
         `CHECK("pa_setting", ev, pa)
      end
      pa_last = pa;
      if (cal_wait == 1) begin
         eb = cal_q.pop_front();
         `CHECK("cal_locked", eb, res !== scpt_pkg::CAL_UNLOCKED)
      end
      if (cal_wait > 0) cal_wait--;
      if (busy_prev && !busy) cal_wait = 3;
      busy_prev = busy;
      if (start === 1'b1) starts++;
   end
   task automatic cyc(int n); repeat (n) @(posedge clock_in); #2; endtask
   function automatic logic [7:0] fresh(logic [7:0] prev);
      logic [7:0] v;
      do v = 8'($urandom_range(255, 1));
      while ((v >= 8'h61 && v <= 8'h6f) || v == prev);
      return v;
   endfunction
   task automatic put(int i, logic [7:0] d, logic b);
      wr = '{wr: 1'b1, burst: b, idx: 3'(i), data: d};
      cyc(1);
      wr.wr = 1'b0;
      cyc(1);
      if (b || i == 0) tbl[i] = d;
   endtask
   task automatic tick(int n);
      repeat (n) begin tx.sym_tick = 1'b1; cyc(1); tx.sym_tick = 1'b0; cyc(3); end
   endtask
   task automatic note(logic [7:0] v);
      if (v !== lastv) pa_q.push_back(v);
      lastv = v;
   endtask
   // ramp up to top then back down; same expectation for ask shaping
   task automatic ramp(int top, logic ask);
      lastv = tbl[0]; tx_watch = 1'b1; pidx = 3'(top);
      for (int i = 1; i <= top; i++) note(tbl[i]);
      for (int i = top - 1; i >= 0; i--) note(tbl[i]);
      tx.ask = ask; tx.data_bit = 1'b1; tx.tx_on = 1'b1;
      tick(top + 2);
      if (ask) begin tx.data_bit = 1'b0; tick(top + 2); end
      tx.tx_on = 1'b0;
      tick(top + 2);
      tx.ask = 1'b0; tx_watch = 1'b0;
      `CHECK("pa_left", 0, pa_q.size())
   endtask
   task automatic cal(logic lk);
      lock = lk; cyc(8); cal_q.push_back(lk); idle = 1'b1; cal_stb = 1'b1;
      cyc(1);
      cal_stb = 1'b0;
      cyc(CAL_T + 8);
      idle = 1'b0;
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 40 && ready !== 1'b1; i++) cyc(1);
      `CHECK("ready", 1'b1, ready)
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin #200_000; fail_count++; final_report(); end
   // main sequence
   initial begin
      int s0;
      logic exp_c;
      s0 = $urandom(52);
      for (int i = 0; i < 8; i++) tbl[i] = scpt_pkg::PWR_DEFAULT;
      cyc(16);
      resetn_in = 1'b1;
      wait_ready();
      `CHECK("pa_reset", scpt_pkg::PWR_DEFAULT, pa)
      `CHECK("res_reset", scpt_pkg::CAL_RESET_VAL, res)
      $display("test reset done");
      put(0, fresh(8'h00), 1'b0);
      for (int i = 1; i < 8; i++) put(i, fresh(tbl[i - 1]), 1'b1);
      put(2, fresh(tbl[2]), 1'b0);
      ramp(7, 1'b0);
      ramp(3, 1'b1);
      ramp(0, 1'b0);
      $display("test ramp done");
      pidx = 3'h1; lastv = tbl[0]; tx_watch = 1'b1; tx.ook = 1'b1;
      tx.tx_on = 1'b1;
      for (int i = 0; i < 4; i++) begin
         tx.data_bit = (i % 2 == 0);
         note(tbl[tx.data_bit]);
         tick(1);
      end
      tx.tx_on = 1'b0; tx.ook = 1'b0;
      cyc(3);
      tx_watch = 1'b0;
      `CHECK("ook_left", 0, pa_q.size())
      $display("test ook done");
      gsel = scpt_pkg::GPO_LOCK_SEL;
      cal(1'b0);
      cal(1'b1);
      for (int l = 0; l < 2; l++) begin
         lock = l[0];
         cyc(8);
         `CHECK("gp_lock", l[0], gp)
      end
      s0 = starts; cal_stb = 1'b1;
      cyc(1);
      cal_stb = 1'b0;
      cyc(4);
      `CHECK("cal_refused", s0, starts)
      $display("test calibrate done");
      for (int m = 0; m < 3; m++) for (int e = 0; e < 2; e++) begin
         acal = 2'(m); s0 = starts;
         exp_c = (m == 1 && e == 0) || (m == 2 && e == 1);
         if (exp_c) cal_q.push_back(1'b1);
         if (e == 0) syn_on = 1'b1; else syn_off = 1'b1;
         cyc(4);
         syn_on = 1'b0; syn_off = 1'b0;
         cyc(CAL_T + 8);
         `CHECK("autocal", exp_c, starts - s0)
      end
      $display("test autocal done");
      gsel = 6'h00; pd_stb = 1'b1;
      cyc(1);
      pd_stb = 1'b0;
      cyc(2);
      wake_req = 1'b0;
      cyc(20);
      `CHECK("core_off", 1'b0, pwr)
      wake_req = 1'b1;
      wait_ready();
      `CHECK("core_on", 2'b11, {pwr, xosc})
      `CHECK("cal_kept", 1'b1, res !== scpt_pkg::CAL_UNLOCKED)
      for (int i = 1; i < 8; i++) tbl[i] = 8'h00;
      ramp(3, 1'b0);
      $display("test sleep done");
      final_report();
   end
endmodule // tb
`default_nettype wire
